/* rtl/dfim_pkg.sv */
// Constants, register map and bus states for the diagnostic flag and interrupt monitor.
// Assumes a single 25 MHz system clock; all byte offsets address the lower page.
package dfim_pkg;

	// Sizes
	localparam int NUM_LANE = 4;
	localparam int NUM_ATTR = 10;
	localparam int NUM_FLAG_BYTES = 8;
	localparam int SYNC_W = 3 + 3 * NUM_LANE;

	// Diagnostic readings, MSB at the even byte
	localparam logic [7:0] OFS_TEMP = 8'h16;
	localparam logic [7:0] OFS_VCC = 8'h1A;
	localparam logic [7:0] OFS_RX_PWR1 = 8'h22;
	localparam logic [7:0] OFS_RX_PWR2 = 8'h24;
	localparam logic [7:0] OFS_RX_PWR3 = 8'h26;
	localparam logic [7:0] OFS_RX_PWR4 = 8'h28;
	localparam logic [7:0] OFS_BIAS1 = 8'h2A;
	localparam logic [7:0] OFS_BIAS2 = 8'h2C;
	localparam logic [7:0] OFS_BIAS3 = 8'h2E;
	localparam logic [7:0] OFS_BIAS4 = 8'h30;
	localparam logic [7:0] LANE_BLOCK_BYTES = 8'h10;

	// Flags, masks and lane control
	localparam logic [7:0] OFS_FLAG_BASE = 8'h03;
	localparam logic [7:0] OFS_MASK_BASE = 8'h64;
	localparam logic [7:0] OFS_LANE_DEACT = 8'h56;
	localparam logic [7:0] OFS_SQ_DIS = 8'h62;
	localparam logic [7:0] FLAG_USED [NUM_FLAG_BYTES] = '{
		8'hFF, 8'h0F, 8'hF0, 8'hF0, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

	// Attribute indices in the reading array
	localparam logic [3:0] ATTR_TEMP = 4'h0;
	localparam logic [3:0] ATTR_VCC = 4'h1;
	localparam logic [3:0] ATTR_RX1 = 4'h2;

	// Reset values
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [SYNC_W-1:0] SYNC_RST = 15'h7000;

	// Target address on the management bus, arbitrary value
	localparam logic [6:0] DEV_ADDR = 7'h50;

	// Power-on initialisation time
	localparam int unsigned MCLK_HZ = 25_000_000;
	localparam int unsigned INIT_TIME_MS = 2000;
	localparam int unsigned INIT_CYCLES_DFLT = INIT_TIME_MS * (MCLK_HZ / 1000);
	localparam int INIT_CNT_W = 26;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX = 3'b001,
		ST_ACK = 3'b010,
		ST_TX = 3'b011,
		ST_TXACK = 3'b100
	} dfim_state_e;

endpackage : dfim_pkg

/* rtl/dfim_monitor.sv */
// Monitoring, latched flags, alert output and lane squelch/disable of a four-lane module,
// reached through a two-wire serial target port.
// Assumes readings and thresholds come from logic on i_mclk; pins are asynchronous.
`timescale 1ns/10ps

// Behaviour
// R01: Compare every reading with alarm and warning thresholds; flag violations.
// R02: Flag transmit loss of input signal and transmit fault per lane.
// R03: Flag receive loss of optical input per lane.
// R04: Flags stay latched after their cause disappears.
// R05: Reading a flag byte clears its latched flags.
// R06: Each flag has a mask bit; a set mask keeps it off the alert.
// R07: Mask bits are volatile and return to zero on reset.
// R08: Transmit loss of signal squelches its lane unless squelch disabled.
// R09: Transmit fault or host deactivation disables the transmit lane.
// R10: Receive loss squelches output unless disabled; host deactivation always squelches.
// R11: Drive a hardware alert output for alarm, warning, loss and fault events.
// R12: Temperature reading at bytes 22 and 23.
// R13: Supply voltage reading at bytes 26 and 27.
// R14: Laser bias lanes one to four at bytes 42 through 49.
// R15: Receive power lanes one to four at bytes 34 through 41.
// R16: Host reads each two-byte field in one uninterrupted read.
// R17: Management port acts only as a bus target.
// R18: Serial access enabled within 2000 ms of power-up.
// R19: Bus clock up to 400 kHz handled correctly.
// R20: Alert is active low while any unmasked latched flag remains set.
module dfim_monitor #(
	parameter int unsigned INIT_CYCLES = dfim_pkg::INIT_CYCLES_DFLT
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_nrst,
	// Two-wire management port
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe_n,
	input wire logic i_module_select_n,
	// Lane status pins
	input wire logic [dfim_pkg::NUM_LANE-1:0] i_tx_los,
	input wire logic [dfim_pkg::NUM_LANE-1:0] i_tx_fault,
	input wire logic [dfim_pkg::NUM_LANE-1:0] i_rx_los,
	// Readings and thresholds
	input wire logic [dfim_pkg::NUM_ATTR-1:0][15:0] i_reading,
	input wire logic [dfim_pkg::NUM_ATTR-1:0][15:0] i_alarm_hi,
	input wire logic [dfim_pkg::NUM_ATTR-1:0][15:0] i_alarm_lo,
	input wire logic [dfim_pkg::NUM_ATTR-1:0][15:0] i_warn_hi,
	input wire logic [dfim_pkg::NUM_ATTR-1:0][15:0] i_warn_lo,
	// Lane control and alert
	output logic [dfim_pkg::NUM_LANE-1:0] o_tx_squelch,
	output logic [dfim_pkg::NUM_LANE-1:0] o_tx_disable,
	output logic [dfim_pkg::NUM_LANE-1:0] o_rx_squelch,
	output logic o_host_alert_n,
	output logic o_mgmt_ready
);
	import dfim_pkg::*;

	logic [SYNC_W-1:0] sync_meta_r;
	logic [SYNC_W-1:0] sync_r;
	logic scl_d_r;
	logic sda_d_r;
	logic scl;
	logic sda;
	logic sel_n;
	logic [NUM_LANE-1:0] tx_los;
	logic [NUM_LANE-1:0] tx_fault;
	logic [NUM_LANE-1:0] rx_los;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	logic [INIT_CNT_W-1:0] init_cnt_r;
	logic ready_r;

	logic [NUM_ATTR-1:0][3:0] attr_cond;
	logic [7:0] flag_set [NUM_FLAG_BYTES];
	logic [7:0] flag_r [NUM_FLAG_BYTES];
	logic [7:0] mask_r [NUM_FLAG_BYTES];
	logic [NUM_FLAG_BYTES-1:0] flag_clr;
	logic [7:0] deact_r;
	logic [7:0] sqdis_r;
	logic pending;

	dfim_state_e state_r;
	logic [7:0] sh_r;
	logic [3:0] cnt_r;
	logic first_r;
	logic ptr_phase_r;
	logic rw_r;
	logic nack_r;
	logic [7:0] ptr_r;
	logic sda_oe_n_r;
	logic sda_out_r;
	logic [7:0] hold_lsb_r;
	logic [7:0] hold_ptr_r;
	logic hold_vld_r;
	logic bus_go;
	logic tx_load;
	logic tx_done;
	logic wr_en;

	logic [7:0] rd_byte;
	logic rd_attr_vld;
	logic [3:0] rd_attr_idx;
	logic [7:0] flag_off;
	logic [7:0] mask_off;
	logic [7:0] lane_off;

	// Pins pass two flops; edges come only from the second stage
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			sync_meta_r <= SYNC_RST;
			sync_r <= SYNC_RST;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			sync_meta_r <= {i_scl, i_sda, i_module_select_n, i_tx_los, i_tx_fault, i_rx_los};
			sync_r <= sync_meta_r;
			scl_d_r <= sync_r[SYNC_W-1];
			sda_d_r <= sync_r[SYNC_W-2];
		end
	end

	assign scl = sync_r[SYNC_W-1];
	assign sda = sync_r[SYNC_W-2];
	assign sel_n = sync_r[SYNC_W-3];
	assign tx_los = sync_r[3*NUM_LANE-1:2*NUM_LANE];
	assign tx_fault = sync_r[2*NUM_LANE-1:NUM_LANE];
	assign rx_los = sync_r[NUM_LANE-1:0];
	// R19: oversampled edges
	assign scl_rise = scl & ~scl_d_r;
	assign scl_fall = ~scl & scl_d_r;
	assign start_det = scl & scl_d_r & sda_d_r & ~sda;
	assign stop_det = scl & scl_d_r & ~sda_d_r & sda;

	// R18: power-on access delay
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			init_cnt_r <= '0;
			ready_r <= 1'b0;
		end else if (!ready_r) begin
			if (init_cnt_r == INIT_CNT_W'(INIT_CYCLES - 1)) begin
				ready_r <= 1'b1;
			end
			init_cnt_r <= init_cnt_r + 1'b1;
		end
	end

	// R01: threshold compare, temperature signed
	always_comb begin
		for (int i = 0; i < NUM_ATTR; i++) begin
			if (i == int'(ATTR_TEMP)) begin
				attr_cond[i][3] = $signed(i_reading[i]) > $signed(i_alarm_hi[i]);
				attr_cond[i][2] = $signed(i_reading[i]) < $signed(i_alarm_lo[i]);
				attr_cond[i][1] = $signed(i_reading[i]) > $signed(i_warn_hi[i]);
				attr_cond[i][0] = $signed(i_reading[i]) < $signed(i_warn_lo[i]);
			end else begin
				attr_cond[i][3] = i_reading[i] > i_alarm_hi[i];
				attr_cond[i][2] = i_reading[i] < i_alarm_lo[i];
				attr_cond[i][1] = i_reading[i] > i_warn_hi[i];
				attr_cond[i][0] = i_reading[i] < i_warn_lo[i];
			end
		end
	end

	// R02 R03: lane events into flag bytes
	always_comb begin
		flag_set[0] = {tx_los, rx_los};
		flag_set[1] = {4'h0, tx_fault};
		flag_set[2] = {attr_cond[ATTR_TEMP], 4'h0};
		flag_set[3] = {attr_cond[ATTR_VCC], 4'h0};
		for (int k = 0; k < 4; k++) begin
			flag_set[4 + k] = {attr_cond[2 + 2 * k], attr_cond[3 + 2 * k]};
		end
	end

	// R04 R05: latched flags, a new event wins over the read clear
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			for (int k = 0; k < NUM_FLAG_BYTES; k++) begin
				flag_r[k] <= 8'h00;
			end
		end else begin
			for (int k = 0; k < NUM_FLAG_BYTES; k++) begin
				flag_r[k] <= (flag_r[k] & ~{8{flag_clr[k]}}) | flag_set[k];
			end
		end
	end

	// R06: unmasked pending flags
	always_comb begin
		pending = 1'b0;
		for (int k = 0; k < NUM_FLAG_BYTES; k++) begin
			pending = pending | (|(flag_r[k] & ~mask_r[k]));
		end
	end

	// R07: masks and lane control cleared on every reset
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			for (int k = 0; k < NUM_FLAG_BYTES; k++) begin
				mask_r[k] <= MASK_RST;
			end
			deact_r <= CTRL_RST;
			sqdis_r <= CTRL_RST;
		end else if (wr_en) begin
			if (mask_off < 8'(NUM_FLAG_BYTES)) begin
				mask_r[mask_off[2:0]] <= sh_r & FLAG_USED[mask_off[2:0]];
			end
			if (ptr_r == OFS_LANE_DEACT) begin
				deact_r <= sh_r;
			end
			if (ptr_r == OFS_SQ_DIS) begin
				sqdis_r <= sh_r;
			end
		end
	end

	// Lane outputs and alert
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_tx_squelch <= '0;
			o_tx_disable <= '0;
			o_rx_squelch <= '0;
			o_host_alert_n <= 1'b1;
			o_mgmt_ready <= 1'b0;
		end else begin
			// R08: transmit squelch
			o_tx_squelch <= tx_los & ~sqdis_r[NUM_LANE-1:0];
			// R09: transmit disable
			o_tx_disable <= tx_fault | deact_r[NUM_LANE-1:0];
			// R10: receive squelch
			o_rx_squelch <= (rx_los & ~sqdis_r[7:4]) | deact_r[7:4];
			// R11 R20: active-low alert
			o_host_alert_n <= ~pending;
			o_mgmt_ready <= ready_r;
		end
	end

	// Read decode
	assign flag_off = ptr_r - OFS_FLAG_BASE;
	assign mask_off = ptr_r - OFS_MASK_BASE;
	assign lane_off = ptr_r - OFS_RX_PWR1;

	// R12 R13 R14 R15: reading map
	always_comb begin
		rd_attr_vld = 1'b1;
		rd_attr_idx = ATTR_TEMP;
		if ((ptr_r & 8'hFE) == OFS_TEMP) begin
			rd_attr_idx = ATTR_TEMP;
		end else if ((ptr_r & 8'hFE) == OFS_VCC) begin
			rd_attr_idx = ATTR_VCC;
		end else if (lane_off < LANE_BLOCK_BYTES) begin
			rd_attr_idx = ATTR_RX1 + lane_off[4:1];
		end else begin
			rd_attr_vld = 1'b0;
		end
	end

	// R16: low byte served from the copy taken with the high byte
	always_comb begin
		rd_byte = 8'h00;
		if (rd_attr_vld) begin
			if (!ptr_r[0]) begin
				rd_byte = i_reading[rd_attr_idx][15:8];
			end else if (hold_vld_r && hold_ptr_r == ptr_r) begin
				rd_byte = hold_lsb_r;
			end else begin
				rd_byte = i_reading[rd_attr_idx][7:0];
			end
		end else if (flag_off < 8'(NUM_FLAG_BYTES)) begin
			rd_byte = flag_r[flag_off[2:0]];
		end else if (mask_off < 8'(NUM_FLAG_BYTES)) begin
			rd_byte = mask_r[mask_off[2:0]];
		end else if (ptr_r == OFS_LANE_DEACT) begin
			rd_byte = deact_r;
		end else if (ptr_r == OFS_SQ_DIS) begin
			rd_byte = sqdis_r;
		end
	end

	assign bus_go = ready_r & ~stop_det & ~(start_det & ~sel_n);
	assign tx_load = bus_go & scl_fall & (((state_r == ST_ACK) & rw_r)
		| ((state_r == ST_TXACK) & ~nack_r));
	assign tx_done = bus_go & scl_fall & (state_r == ST_TX) & (cnt_r == 4'h8);
	assign wr_en = bus_go & scl_fall & (state_r == ST_RX) & (cnt_r == 4'h8)
		& ~first_r & ~ptr_phase_r;

	// R05: clear a flag byte once it has gone out on the bus
	always_comb begin
		flag_clr = '0;
		if (tx_done && flag_off < 8'(NUM_FLAG_BYTES)) begin
			flag_clr[flag_off[2:0]] = 1'b1;
		end
	end

	// Coherent copy of the low byte
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			hold_lsb_r <= 8'h00;
			hold_ptr_r <= 8'h00;
			hold_vld_r <= 1'b0;
		end else if (tx_load) begin
			hold_vld_r <= rd_attr_vld & ~ptr_r[0];
			hold_ptr_r <= ptr_r + 8'h01;
			hold_lsb_r <= i_reading[rd_attr_idx][7:0];
		end
	end

	// R17: target-only bus engine; never drives the clock
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_r <= ST_IDLE;
			sh_r <= 8'h00;
			cnt_r <= 4'h0;
			first_r <= 1'b0;
			ptr_phase_r <= 1'b0;
			rw_r <= 1'b0;
			nack_r <= 1'b0;
			ptr_r <= 8'h00;
			sda_oe_n_r <= 1'b1;
		end else if (stop_det || !ready_r) begin
			state_r <= ST_IDLE;
			sda_oe_n_r <= 1'b1;
		end else if (start_det && !sel_n) begin
			state_r <= ST_RX;
			cnt_r <= 4'h0;
			first_r <= 1'b1;
			sda_oe_n_r <= 1'b1;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					sda_oe_n_r <= 1'b1;
				end
				ST_RX: begin
					if (scl_rise) begin
						sh_r <= {sh_r[6:0], sda};
						cnt_r <= cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == 4'h8) begin
						if (first_r && sh_r[7:1] != DEV_ADDR) begin
							state_r <= ST_IDLE;
						end else begin
							if (first_r) begin
								rw_r <= sh_r[0];
								ptr_phase_r <= ~sh_r[0];
							end else if (ptr_phase_r) begin
								ptr_r <= sh_r;
								ptr_phase_r <= 1'b0;
							end else begin
								ptr_r <= ptr_r + 8'h01;
							end
							state_r <= ST_ACK;
							sda_oe_n_r <= 1'b0;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						first_r <= 1'b0;
						cnt_r <= 4'h0;
						if (rw_r) begin
							state_r <= ST_TX;
							sh_r <= rd_byte;
							sda_oe_n_r <= rd_byte[7];
						end else begin
							state_r <= ST_RX;
							sda_oe_n_r <= 1'b1;
						end
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						cnt_r <= cnt_r + 4'h1;
					end else if (scl_fall) begin
						if (cnt_r == 4'h8) begin
							sda_oe_n_r <= 1'b1;
							state_r <= ST_TXACK;
							ptr_r <= ptr_r + 8'h01;
						end else begin
							sh_r <= {sh_r[6:0], 1'b0};
							sda_oe_n_r <= sh_r[6];
						end
					end
				end
				ST_TXACK: begin
					if (scl_rise) begin
						nack_r <= sda;
					end else if (scl_fall) begin
						cnt_r <= 4'h0;
						if (nack_r) begin
							state_r <= ST_IDLE;
						end else begin
							state_r <= ST_TX;
							sh_r <= rd_byte;
							sda_oe_n_r <= rd_byte[7];
						end
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Open drain: the data pin is only ever pulled low
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			sda_out_r <= 1'b0;
		end else begin
			sda_out_r <= 1'b0;
		end
	end

	assign o_sda_out = sda_out_r;
	assign o_sda_oe_n = sda_oe_n_r;

endmodule : dfim_monitor

/* verification/dfim_props.sv */
// Checker for the monitor's bus drive, ready timing and transmit lane outputs.
// Assumes the host keeps SCL low for at least four system clocks.
`timescale 1ns/10ps
module dfim_props #(
	parameter int unsigned INIT_CYCLES = 16
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_nrst,
	// Watched pins
	input wire logic i_scl,
	input wire logic [dfim_pkg::NUM_LANE-1:0] i_tx_los,
	input wire logic [dfim_pkg::NUM_LANE-1:0] i_tx_fault,
	input wire logic o_sda_out,
	input wire logic o_sda_oe_n,
	input wire logic [dfim_pkg::NUM_LANE-1:0] o_tx_squelch,
	input wire logic [dfim_pkg::NUM_LANE-1:0] o_tx_disable,
	input wire logic o_host_alert_n,
	input wire logic o_mgmt_ready
);
	int unsigned up_r;
	// Saturates so the lane checks wait out the synchroniser after reset
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			up_r <= 0;
		end else if (up_r < INIT_CYCLES + 8) begin
			up_r <= up_r + 1;
		end
	end
	default clocking dck @(posedge i_mclk);
	endclocking
	default disable iff (!i_nrst);
	sda_low_only_a:
		assert property (o_sda_out == 1'b0) else $error("data drive level not low");
	quiet_early_a:
		assert property (!o_mgmt_ready |-> o_sda_oe_n) else $error("bus driven before ready");
	ready_hold_a:
		assert property (o_mgmt_ready |=> o_mgmt_ready) else $error("ready dropped");
	ready_time_a:
		assert property ($rose(o_mgmt_ready) |-> up_r inside {[INIT_CYCLES:INIT_CYCLES + 2]})
			else $error("ready at wrong time");
	tx_squelch_a:
		assert property ((up_r > 3) |-> (o_tx_squelch & ~$past(i_tx_los, 3)) == 4'h0)
			else $error("squelch without loss");
	tx_disable_a:
		assert property ((up_r > 3) |-> ($past(i_tx_fault, 3) & ~o_tx_disable) == 4'h0)
			else $error("fault lane not disabled");
	drive_edge_a:
		assert property ($changed(o_sda_oe_n) |-> !$past(i_scl, 2)) else $error("drive moved in high");
	drive_hold_a:
		assert property ($fell(o_sda_oe_n) |=> !o_sda_oe_n [*5]) else $error("drive too short");
	ack_seen_c: cover property ($fell(o_sda_oe_n));
	alert_on_c: cover property ($fell(o_host_alert_n));
	alert_off_c: cover property ($rose(o_host_alert_n));
	squelch_c: cover property ($rose(o_tx_squelch[1]));
endmodule : dfim_props
bind dfim_monitor dfim_props #(.INIT_CYCLES(INIT_CYCLES)) u_props (
	.i_mclk, .i_nrst, .i_scl, .i_tx_los, .i_tx_fault, .o_sda_out, .o_sda_oe_n,
	.o_tx_squelch, .o_tx_disable, .o_host_alert_n, .o_mgmt_ready
);

/* verification/dfim_host_model.sv */
// Host controller model for the two-wire management bus, target at the package address.
// Assumes a pull-up on the data wire; the bench resolves the wire and feeds it back.
`timescale 1ns/10ps
module dfim_host_model (
	// Clock and wire
	input wire logic i_mclk,
	input wire logic i_sda,
	// Bus drive, one means released
	output logic o_scl,
	output logic o_sda_rel,
	output logic o_module_select_n
);
	import dfim_pkg::*;
	int q;
	logic nak;
	initial begin
		q = 2;
		nak = 1'b0;
		o_scl = 1'b1;
		o_sda_rel = 1'b1;
		o_module_select_n = 1'b0;
	end
	// quarter period of two clocks or more
	task automatic wq();
		repeat (q) @(negedge i_mclk);
	endtask : wq
	// Start is (1,0), stop is (0,1); SCL then stays high
	task automatic edge2(input logic a, input logic b);
		o_scl = 1'b0;
		wq();
		o_sda_rel = a;
		wq();
		o_scl = 1'b1;
		wq();
		o_sda_rel = b;
		wq();
	endtask : edge2
	task automatic bits(input logic [8:0] d, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			o_scl = 1'b0;
			wq();
			o_sda_rel = d[i];
			wq();
			o_scl = 1'b1;
			wq();
			r[i] = i_sda;
			wq();
		end
	endtask : bits
	// two-byte field in one read; m: 0 write, 1 one byte, 2 two bytes
	task automatic xact(input logic [1:0] m, input logic [7:0] p, input logic [7:0] wd,
			output logic [15:0] v);
		logic [8:0] r;
		v = 16'h0000;
		edge2(1'b1, 1'b0);
		bits({DEV_ADDR, 2'b01}, r);
		nak = r[0];
		bits({p, 1'b1}, r);
		nak |= r[0];
		if (m == 2'd0) begin
			bits({wd, 1'b1}, r);
			nak |= r[0];
		end else begin
			edge2(1'b1, 1'b0);
			bits({DEV_ADDR, 2'b11}, r);
			nak |= r[0];
			bits({8'hFF, m == 2'd1}, r);
			v[15:8] = r[8:1];
			if (m == 2'd2) begin
				bits(9'h1FF, r);
				v[7:0] = r[8:1];
			end
		end
		edge2(1'b0, 1'b1);
	endtask : xact
endmodule : dfim_host_model

/* verification/dfim_monitor_tb.sv */
// Self-checking bench for the diagnostic flag and interrupt monitor.
// Assumes the host model owns the bus; lane pins and readings are driven here.
`timescale 1ns/10ps
module dfim_monitor_tb;
	import dfim_pkg::*;
	typedef struct { logic [7:0] ptr; logic [15:0] exp; } dfim_row_s;
	logic clk, nrst, sda_oe_n, sda_out, alert_n, ready;
	logic [NUM_LANE-1:0] tx_los, tx_fault, rx_los, tx_sq, tx_dis, rx_sq;
	logic [NUM_ATTR-1:0][15:0] rdg, ahi, alo, whi, wlo;
	logic [15:0] v;
	logic [7:0] ofs [NUM_ATTR] = '{OFS_TEMP, OFS_VCC, OFS_RX_PWR1, OFS_RX_PWR2, OFS_RX_PWR3,
		OFS_RX_PWR4, OFS_BIAS1, OFS_BIAS2, OFS_BIAS3, OFS_BIAS4};
	dfim_row_s rows [NUM_ATTR];
	wire logic scl, sda_rel, sel_n, sda;
	int errors, compares;
	// Open-drain wire with pull-up
	assign sda = sda_rel & (sda_oe_n | sda_out);
	dfim_monitor #(.INIT_CYCLES(16)) dut (
		.i_mclk(clk), .i_nrst(nrst), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
		.o_sda_oe_n(sda_oe_n), .i_module_select_n(sel_n), .i_tx_los(tx_los),
		.i_tx_fault(tx_fault), .i_rx_los(rx_los), .i_reading(rdg), .i_alarm_hi(ahi),
		.i_alarm_lo(alo), .i_warn_hi(whi), .i_warn_lo(wlo), .o_tx_squelch(tx_sq),
		.o_tx_disable(tx_dis), .o_rx_squelch(rx_sq), .o_host_alert_n(alert_n),
		.o_mgmt_ready(ready)
	);
	dfim_host_model host (
		.i_mclk(clk), .i_sda(sda), .o_scl(scl), .o_sda_rel(sda_rel), .o_module_select_n(sel_n)
	);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic complete_run();
		if (errors == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic rd1(input logic [7:0] p);
		host.xact(2'd1, p, 8'h00, v);
	endtask : rd1
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		host.xact(2'd0, p, d, v);
		chk(host.nak, 1'b0);
	endtask : wr
	task automatic do_reset();
		nrst = 1'b0;
		cyc(20);
		nrst = 1'b1;
		for (int i = 0; i < 100 && ready !== 1'b1; i++) cyc(1);
		chk(ready, 1'b1);
	endtask : do_reset
	// Lane pins held for long enough to pass the synchroniser
	task automatic pulse(input logic [3:0] t, input logic [3:0] r);
		tx_los = t;
		rx_los = r;
		cyc(6);
		tx_los = 4'h0;
		rx_los = 4'h0;
		cyc(6);
	endtask : pulse
	initial begin
		#2_000_000;
		errors++;
		complete_run();
	end
	initial begin
		nrst = 1'b0;
		{tx_los, tx_fault, rx_los} = '0;
		for (int a = 0; a < NUM_ATTR; a++) begin
			rows[a] = '{ofs[a], {4'(a), 8'hA5, 4'(a)}};
			rdg[a] = rows[a].exp;
			ahi[a] = (a == 0) ? 16'h7FFF : 16'hFFFE;
			alo[a] = (a == 0) ? 16'h8000 : 16'h0001;
		end
		whi = ahi;
		wlo = alo;
		do_reset();
		chk(alert_n, 1'b1);
		for (int a = 0; a < NUM_ATTR; a++) begin
			host.xact(2'd2, rows[a].ptr, 8'h00, v);
			chk(v, rows[a].exp);
		end
		host.q = 4;
		host.xact(2'd2, OFS_VCC, 8'h00, v);
		chk(v, rows[1].exp);
		host.q = 2;
		rd1(8'hF0);
		chk(v, 16'h0000);
		tx_los = 4'h2;
		cyc(6);
		chk(tx_sq, 4'h2);
		pulse(4'h0, 4'h0);
		chk(alert_n, 1'b0);
		rd1(OFS_FLAG_BASE);
		chk(v[15:8], 8'h20);
		cyc(4);
		chk(alert_n, 1'b1);
		rd1(OFS_FLAG_BASE);
		chk(v[15:8], 8'h00);
		wr(OFS_MASK_BASE, 8'h20);
		pulse(4'h2, 4'h0);
		chk(alert_n, 1'b1);
		rd1(OFS_MASK_BASE);
		chk(v[15:8], 8'h20);
		rd1(OFS_FLAG_BASE);
		chk(v[15:8], 8'h20);
		do_reset();
		rd1(OFS_MASK_BASE);
		chk(v[15:8], 8'h00);
		rx_los = 4'h1;
		cyc(6);
		chk(rx_sq, 4'h1);
		pulse(4'h2, 4'h0);
		chk(alert_n, 1'b0);
		rd1(OFS_FLAG_BASE);
		chk(v[15:8], 8'h21);
		tx_fault = 4'h4;
		cyc(6);
		chk(tx_dis, 4'h4);
		tx_fault = 4'h0;
		rd1(OFS_FLAG_BASE + 8'h01);
		chk(v[15:8], 8'h04);
		wr(OFS_LANE_DEACT, 8'h81);
		cyc(4);
		chk(tx_dis, 4'h1);
		chk(rx_sq, 4'h8);
		wr(OFS_LANE_DEACT, 8'h00);
		wr(OFS_SQ_DIS, 8'h11);
		tx_los = 4'h1;
		rx_los = 4'h1;
		cyc(6);
		chk(tx_sq, 4'h0);
		chk(rx_sq, 4'h0);
		pulse(4'h0, 4'h0);
		rd1(OFS_FLAG_BASE);
		chk(v[15:8], 8'h11);
		// Negative temperature trips the low warning only when compared signed
		rdg[0] = 16'hFF00;
		wlo[0] = 16'h0000;
		ahi[1] = 16'h0001;
		cyc(6);
		rdg[0] = rows[0].exp;
		wlo[0] = alo[0];
		ahi[1] = 16'hFFFE;
		host.xact(2'd2, OFS_FLAG_BASE + 8'h02, 8'h00, v);
		chk(v, 16'h1080);
		complete_run();
	end
endmodule : dfim_monitor_tb
